// file: sleep_clock_gating_consts.svh
// Constants of the sleep clock gating block.
`ifndef SLEEP_CLOCK_GATING_CONSTS_SVH
`define SLEEP_CLOCK_GATING_CONSTS_SVH

`define ADDR_W              12
`define OFF_SLEEP_GATE      12'h118
`define OFF_GATE_CFG        12'h11C
`define OFF_FAULT_STATUS    12'h120
`define OFF_FAULT_MASK      12'h124
`define BIT_PHY_CLOCK_EN    30
`define BIT_MAC_CLOCK_EN    28
`define BIT_PORT_G_CLOCK_EN 6
`define BIT_PORT_A_CLOCK_EN 0
`define BIT_SLEEP_GATE_SEL  0
`define GATE_MASK           32'h5000_007F
`define GATE_RESET          32'h0000_0000
`define CFG_MASK            32'h0000_0001
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: sleep_clock_gating_pkg.sv
// Types and helpers of the sleep clock gating block.
package sleep_clock_gating_pkg;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP_SLEEP
  } power_mode_t;

  typedef logic [31:0] word_t;

  // Merges write data into an old value under byte strobes and a mask.
  function automatic word_t strobe_merge(word_t old_val, word_t new_val,
                                         logic [3:0] strb, word_t mask);
    word_t res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : strobe_merge

endpackage : sleep_clock_gating_pkg

// file: gate_if.sv
// Carrier between the gating controller and the fault checker.
interface gate_if;
  logic [31:0] clk_en;
  logic [31:0] access;
  logic [31:0] fault;

  modport ctrl (output clk_en, output access, input fault);
  modport chk  (input clk_en, input access, output fault);
endinterface : gate_if

// file: gate_fault_check.sv
// Flags unit accesses that land on an unclocked unit.
`include "sleep_clock_gating_consts.svh"

module gate_fault_check (
  input wire logic aclk,
  input wire logic aresetn,
  gate_if.chk      gate
);
  import sleep_clock_gating_pkg::*;

  logic [31:0] fault_reg;
  logic [31:0] fault_next;

  always_comb begin
    fault_next = gate.access & ~gate.clk_en & `GATE_MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_reg <= 32'h0000_0000;
    end else begin
      fault_reg <= fault_next;
    end
  end

  assign gate.fault = fault_reg;

endmodule : gate_fault_check

// file: sleep_clock_gating.sv
// Sleep-mode unit clock gating register with AXI4-Lite access.
//
// Design decision made here: the AXI4-Lite register port.
`include "sleep_clock_gating_consts.svh"

module sleep_clock_gating (
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  input  wire logic [`ADDR_W-1:0]                 s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [`ADDR_W-1:0]                 s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  input  wire sleep_clock_gating_pkg::power_mode_t power_mode,
  input  wire logic [31:0]                        run_gate_en,
  input  wire logic [31:0]                        deep_gate_en,
  input  wire logic [31:0]                        unit_access,
  output logic [31:0]                             unit_clk_en,
  output logic [31:0]                             unit_fault,
  output logic                                    irq
);
  import sleep_clock_gating_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic               aw_full_reg, aw_full_next;
  logic [`ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic               w_full_reg, w_full_next;
  logic [31:0]        w_data_reg, w_data_next;
  logic [3:0]         w_strb_reg, w_strb_next;
  logic               awready_reg, awready_next;
  logic               wready_reg, wready_next;
  logic               bvalid_reg, bvalid_next;
  logic [1:0]         bresp_reg, bresp_next;
  logic               arready_reg, arready_next;
  logic               rvalid_reg, rvalid_next;
  logic [31:0]        rdata_reg, rdata_next;
  logic [1:0]         rresp_reg, rresp_next;
  logic [31:0]        sleep_reg, sleep_next;
  logic [31:0]        cfg_reg, cfg_next;
  logic [31:0]        status_reg, status_next;
  logic [31:0]        mask_reg, mask_next;
  logic [31:0]        clk_en_reg, clk_en_next;
  logic               irq_reg, irq_next;
  logic               do_write;
  logic               take_ar;
  logic [31:0]        gated_hit;

  gate_if gate ();

  gate_fault_check u_fault_check (
    .aclk    (aclk),
    .aresetn (aresetn),
    .gate    (gate.chk)
  );

  assign gate.clk_en = clk_en_reg;
  assign gate.access = unit_access;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and registers.

  always_comb begin
    do_write     = aw_full_reg && w_full_reg && !bvalid_reg;
    take_ar      = s_axi_arvalid && arready_reg;
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bresp_next   = bresp_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    sleep_next   = sleep_reg;
    cfg_next     = cfg_reg;
    mask_next    = mask_reg;
    status_next  = status_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bresp_next   = `RESP_OKAY;
      if (aw_addr_reg == `OFF_SLEEP_GATE) begin
        sleep_next = strobe_merge(sleep_reg, w_data_reg, w_strb_reg,
                                  `GATE_MASK);
      end else if (aw_addr_reg == `OFF_GATE_CFG) begin
        cfg_next = strobe_merge(cfg_reg, w_data_reg, w_strb_reg, `CFG_MASK);
      end else if (aw_addr_reg == `OFF_FAULT_MASK) begin
        mask_next = strobe_merge(mask_reg, w_data_reg, w_strb_reg,
                                 `GATE_MASK);
      end else if (aw_addr_reg == `OFF_FAULT_STATUS) begin
        status_next = status_reg & ~strobe_merge(32'h0000_0000, w_data_reg,
                                                 w_strb_reg, `GATE_MASK);
      end else begin
        bresp_next = `RESP_SLVERR;
      end
    end
    // A fault in the same cycle as its clear keeps the bit set.
    status_next  = status_next | gate.fault;
    bvalid_next  = do_write || (bvalid_reg && !s_axi_bready);
    awready_next = !aw_full_next;
    wready_next  = !w_full_next;
    if (take_ar) begin
      rresp_next = `RESP_OKAY;
      if (s_axi_araddr == `OFF_SLEEP_GATE) begin
        rdata_next = sleep_reg & `GATE_MASK;
      end else if (s_axi_araddr == `OFF_GATE_CFG) begin
        rdata_next = cfg_reg;
      end else if (s_axi_araddr == `OFF_FAULT_STATUS) begin
        rdata_next = status_reg;
      end else if (s_axi_araddr == `OFF_FAULT_MASK) begin
        rdata_next = mask_reg;
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = `RESP_SLVERR;
      end
    end
    rvalid_next  = take_ar || (rvalid_reg && !s_axi_rready);
    arready_next = !rvalid_next;
    irq_next     = |(status_next & mask_next);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enable selection.

  always_comb begin
    clk_en_next = run_gate_en;
    case (power_mode)
      MODE_SLEEP: begin
        if (cfg_reg[`BIT_SLEEP_GATE_SEL]) begin
          clk_en_next = sleep_reg;
        end
      end
      MODE_DEEP_SLEEP: begin
        if (cfg_reg[`BIT_SLEEP_GATE_SEL]) begin
          clk_en_next = deep_gate_en;
        end
      end
      default: begin
        clk_en_next = run_gate_en;
      end
    endcase
    clk_en_next = clk_en_next & `GATE_MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `RESP_OKAY;
      sleep_reg   <= `GATE_RESET;
      cfg_reg     <= 32'h0000_0000;
      status_reg  <= 32'h0000_0000;
      mask_reg    <= 32'h0000_0000;
      clk_en_reg  <= 32'h0000_0000;
      irq_reg     <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      sleep_reg   <= sleep_next;
      cfg_reg     <= cfg_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      clk_en_reg  <= clk_en_next;
      irq_reg     <= irq_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign unit_clk_en   = clk_en_reg;
  assign unit_fault    = gate.fault;
  assign irq           = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  assign gated_hit = unit_access & ~clk_en_reg & `GATE_MASK;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_sleep_gate_write;
    do_write && aw_addr_reg == `OFF_SLEEP_GATE && w_strb_reg == 4'hF;
  endsequence

  sequence s_sleep_gate_read;
    take_ar && s_axi_araddr == `OFF_SLEEP_GATE;
  endsequence

  property p_sleep_clocks;
    (power_mode == MODE_SLEEP && cfg_reg[`BIT_SLEEP_GATE_SEL])
      |=> unit_clk_en == $past(sleep_reg);
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks)
    else $error("Sleep clock enables do not follow the gating register.");

  property p_gated_fault;
    1'b1 |=> unit_fault == $past(gated_hit);
  endproperty
  a_gated_fault: assert property (p_gated_fault)
    else $error("Fault output does not match access to an unclocked unit.");

  property p_reset_clear;
    $rose(aresetn)
      |-> sleep_reg == 32'h0000_0000 && unit_clk_en == 32'h0000_0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Gating state is not clear after reset.");

  property p_run_ignores_sleep;
    power_mode == MODE_RUN
      |=> unit_clk_en == ($past(run_gate_en) & `GATE_MASK);
  endproperty
  a_run_ignores_sleep: assert property (p_run_ignores_sleep)
    else $error("Run mode clock enables do not follow the run gating input.");

  property p_select_off;
    (power_mode == MODE_SLEEP && !cfg_reg[`BIT_SLEEP_GATE_SEL])
      |=> unit_clk_en == ($past(run_gate_en) & `GATE_MASK);
  endproperty
  a_select_off: assert property (p_select_off)
    else $error("Sleep gating used although the select bit is clear.");

  property p_field_write;
    s_sleep_gate_write |=> sleep_reg == ($past(w_data_reg) & `GATE_MASK);
  endproperty
  a_field_write: assert property (p_field_write)
    else $error("Gating register write did not store the enable fields.");

  property p_reserved_read;
    s_sleep_gate_read |=> rvalid_reg
      && (s_axi_rdata & ~`GATE_MASK) == 32'h0000_0000
      && s_axi_rresp == `RESP_OKAY;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("Reserved gating bits did not read as zero.");

  property p_reserved_hold;
    (sleep_reg & ~`GATE_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_hold: assert property (p_reserved_hold)
    else $error("A reserved gating bit was stored.");

  // A fault must leave its status bit set even when a clear lands with it.
  property p_fault_sticky;
    unit_fault != 32'h0000_0000
      |=> (status_reg & $past(unit_fault)) == $past(unit_fault);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("A unit fault did not set its status bit.");

  property p_irq_level;
    irq == |(status_reg & mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt output does not follow unmasked status.");

  property p_write_answer;
    s_sleep_gate_write |=> s_axi_bvalid && s_axi_bresp == `RESP_OKAY;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("Gating register write was not answered with OKAY.");

endmodule : sleep_clock_gating

// file: unit_bus_model.sv
// Model of the gated units: turns an access request into a unit strobe.
module unit_bus_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        req,
  input  wire logic [4:0]  idx,
  output logic      [31:0] unit_access
);
  timeunit 1ns;
  timeprecision 1ps;

  initial unit_access = '0;

  // A bus access aimed at one unit lasts one cycle.
  always @(posedge aclk) begin
    unit_access <= (aresetn && req) ? 32'h0000_0001 << idx : '0;
  end
endmodule : unit_bus_model

// file: sleep_clock_gating_tb.sv
// Self-checking testbench of the sleep clock gating block.
`include "sleep_clock_gating_consts.svh"

module sleep_clock_gating_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_clock_gating_pkg::*;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] run_en = '0;
  logic [31:0] deep_en = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        req = 1'b0;
  logic [3:0]  strb = 4'hF;
  logic [4:0]  idx = '0;
  power_mode_t mode = MODE_RUN;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, clk_en, fault, access;
  int          failures = 0;
  int          checked = 0;
  logic [1:0]  wq[$];
  logic [33:0] rq[$];

  sleep_clock_gating dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_mode(mode),
    .run_gate_en(run_en), .deep_gate_en(deep_en),
    .unit_access(access), .unit_clk_en(clk_en), .unit_fault(fault),
    .irq(irq)
  );

  unit_bus_model model_u (
    .aclk(aclk), .aresetn(aresetn), .req(req), .idx(idx),
    .unit_access(access)
  );

  initial begin
    forever #25 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r, input logic [3:0] s = 4'hF);
    @(posedge aclk);
    wq.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    strb    <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    @(posedge aclk);
    rq.push_back(exp);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // Counts fault cycles that follow one access to unit b.
  task automatic poke(input logic [4:0] b, input logic hit);
    logic [33:0] cnt;
    cnt = '0;
    @(posedge aclk);
    idx <= b;
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    repeat (8) begin
      @(posedge aclk);
      cnt += 34'(fault[b]);
    end
    check(cnt, 34'(hit));
  endtask : poke

  // Bus answers are compared with the oldest expectation at handshake.
  always @(posedge aclk) begin
    if (bvalid && bready) check({32'h0, bresp}, {32'h0, wq.pop_front()});
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
  end

  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] g;
    logic [31:0] e;
    void'($urandom(70));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({2'b00, clk_en}, 34'h0);
    rd(`OFF_SLEEP_GATE, {`RESP_OKAY, `GATE_RESET});
    rd(12'h200, {`RESP_SLVERR, 32'h0000_0000});
    wr(12'h200, 32'hFFFF_FFFF, `RESP_SLVERR);
    wr(`OFF_SLEEP_GATE, 32'hFFFF_FFFF, `RESP_OKAY);
    rd(`OFF_SLEEP_GATE, {`RESP_OKAY, `GATE_MASK});
    wr(`OFF_SLEEP_GATE, 32'hAFFF_FF80, `RESP_OKAY);
    rd(`OFF_SLEEP_GATE, {`RESP_OKAY, 32'h0000_0000});
    wr(`OFF_SLEEP_GATE, 32'hFFFF_FFFF, `RESP_OKAY, 4'h8);
    rd(`OFF_SLEEP_GATE, {`RESP_OKAY, 32'h5000_0000});
    $display("register test done");

    // Every mode with the select bit clear, then set.
    for (int i = 0; i < 6; i++) begin
      g = $urandom;
      run_en  <= $urandom;
      deep_en <= $urandom;
      mode    <= power_mode_t'(i % 3);
      wr(`OFF_GATE_CFG, 32'(i / 3), `RESP_OKAY);
      wr(`OFF_SLEEP_GATE, g, `RESP_OKAY);
      rd(`OFF_SLEEP_GATE, {`RESP_OKAY, g & `GATE_MASK});
      rd(`OFF_GATE_CFG, {`RESP_OKAY, 32'(i / 3)});
      repeat (3) @(posedge aclk);
      e = (i < 3 || mode == MODE_RUN) ? run_en :
          (mode == MODE_SLEEP) ? g : deep_en;
      check({2'b00, clk_en}, {2'b00, e & `GATE_MASK});
    end
    $display("mode test done");

    mode <= MODE_SLEEP;
    wr(`OFF_GATE_CFG, 32'h0000_0001, `RESP_OKAY);
    wr(`OFF_SLEEP_GATE, 32'h0000_0000, `RESP_OKAY);
    wr(`OFF_FAULT_MASK, 32'h0000_0000, `RESP_OKAY);
    poke(5'd28, 1'b1);
    check({33'h0, irq}, 34'h0);
    rd(`OFF_FAULT_STATUS, {`RESP_OKAY, 32'h1000_0000});
    wr(`OFF_FAULT_MASK, `GATE_MASK, `RESP_OKAY);
    rd(`OFF_FAULT_MASK, {`RESP_OKAY, `GATE_MASK});
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h1);
    wr(`OFF_FAULT_STATUS, 32'h1000_0000, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    poke(5'($urandom_range(6, 0)), 1'b1);
    wr(`OFF_SLEEP_GATE, 32'h1000_0000, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    poke(5'd28, 1'b0);
    $display("fault test done");
    stop_test();
  end
endmodule : sleep_clock_gating_tb
